// ### common/e1am_consts.svh
/*
 * Register indices, field positions, reset values and timing counts
 * for the E1 receive alarm supervisor.
 * Assumes a 10 MHz system clock; included by its bare name.
 */
`ifndef E1AM_CONSTS_SVH
`define E1AM_CONSTS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define E1AM_IDX_LIVE      8'hb9
`define E1AM_IDX_IRQ_EN    8'hba
`define E1AM_IDX_CHANGE    8'hbb
`define E1AM_IDX_CRITERIA  8'hbc
`define E1AM_IDX_PM_CTRL   8'hc2
`define E1AM_IDX_OVF_EN_A  8'hc3
`define E1AM_IDX_OVF_EN_B  8'hc4
`define E1AM_IDX_OVF_FLG_A 8'hc5
`define E1AM_IDX_OVF_FLG_B 8'hc6

// ==========================================================
// Field positions and reset values
`define E1AM_CRIT_AIS_BIT  5
`define E1AM_CRIT_RAI_BIT  4
`define E1AM_PM_MANUAL_BIT 5
`define E1AM_PM_AUTO_BIT   4
`define E1AM_LCV_EN_BIT    0
`define E1AM_RESET_BYTE    8'h00

// ==========================================================
// Detection counts
`define E1AM_LOS_RUN       16
`define E1AM_T16_PERIOD    16
`define E1AM_T16_ZERO_MIN  4
`define E1AM_AIS_WINDOW    512
`define E1AM_AIS_ZERO_MIN  3
`define E1AM_Y_RUN         3
`define E1AM_A_RUN         4

// ==========================================================
// Timing
`define E1AM_CLK_HZ        10000000
`define E1AM_RED_TIME_MS   100
`define E1AM_AUTO_TIME_S   1

`endif

// ### common/e1am_pkg.sv
/*
 * Types shared by the E1 receive alarm supervisor.
 * Assumes the framer delivers its strobes on the system clock.
 */
package e1am_pkg;

	// ==========================================================
	// Received stream as seen from the framer
	typedef struct packed {
		logic       frame_aligned;
		logic       mf_aligned;
		logic       bit_valid;
		logic       bit_data;
		logic       ts16_valid;
		logic [7:0] ts16_octet;
		logic       a_valid;
		logic       a_bit;
		logic       y_valid;
		logic       y_bit;
	} e1am_rx_s;

	// Counter overflow pulses, bit 8 is line code violation
	typedef logic [8:0] e1am_ovf_t;

endpackage : e1am_pkg

// ### logic/e1am_top.sv
/*
 * E1 receive alarm supervisor with AHB-Lite register slave.
 * Assumes framer strobes and overflow pulses come from logic on clk_in,
 * and a single AHB-Lite master issuing single word transfers.
 */
`include "e1am_consts.svh"

module e1am_top #(
	parameter int unsigned RED_CYCLES  =
		(`E1AM_RED_TIME_MS * `E1AM_CLK_HZ) / 1000,
	parameter int unsigned AUTO_CYCLES =
		`E1AM_AUTO_TIME_S * `E1AM_CLK_HZ
) (
	// Clock and reset
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	// AHB-Lite slave
	input  wire logic              hsel_in,
	input  wire logic [31:0]       haddr_in,
	input  wire logic [1:0]        htrans_in,
	input  wire logic              hwrite_in,
	input  wire logic [2:0]        hsize_in,
	input  wire logic [31:0]       hwdata_in,
	input  wire logic              hready_in,
	output logic      [31:0]       hrdata_out,
	output logic                   hreadyout_out,
	output logic                   hresp_out,
	// Framer side
	input  wire e1am_pkg::e1am_rx_s rx_in,
	input  wire e1am_pkg::e1am_ovf_t ovf_pulse_in,
	// Outputs
	output logic                   irq_out,
	output logic                   perfmon_update_out
);

	// ==========================================================
	// Elaboration checks
	if (RED_CYCLES < 1 || AUTO_CYCLES < 1) begin : g_chk
		$error("e1am_top: cycle counts must be at least one");
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	// ==========================================================
	// Helper functions
	function automatic logic [3:0] zeros_in(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'h0, ~v[i]};
		end
		return n;
	endfunction : zeros_in

	function automatic logic is_idx(input logic [31:0] a,
			input logic [7:0] idx);
		return (a[31:10] == 22'h0) && (a[9:2] == idx) && (a[1:0] == 2'h0);
	endfunction : is_idx

	// ==========================================================
	// Registers
	logic [5:0] live;          // [5] los16 [4] ais16 [3] rma [2] ais [1] rai [0] red
	logic       slot16_loss_status;
	logic       slot16_ais_status;
	logic       remote_multiframe_alarm_status;
	logic       all_ones_alarm_status;
	logic       remote_alarm_status;
	logic       frame_loss_status;
	logic [5:0] irq_en;
	logic [5:0] change;
	logic       all_ones_criterion_sel;
	logic       remote_alarm_criterion_sel;
	logic       perfmon_manual_update;
	logic       perfmon_auto_update;
	logic [7:0] ovf_en_a;
	logic       line_code_viol_ovf_irq_en;
	logic [8:0] ovf_flag;
	logic [5:0] live_prev;
	logic [5:0] live_toggle;

	// Each detector owns its own status flop; the word serves reads and change detection
	assign live = {slot16_loss_status, slot16_ais_status,
		remote_multiframe_alarm_status, all_ones_alarm_status,
		remote_alarm_status, frame_loss_status};
	assign live_toggle = live ^ live_prev;

	// ==========================================================
	// AHB-Lite slave: address phase captured, write done in data phase
	logic       dp_write;
	logic [7:0] dp_idx;
	logic       take;
	logic       wr;
	logic [7:0] wdat;

	assign take = hsel_in && hready_in && htrans_in[1];
	assign wr   = dp_write;
	assign wdat = hwdata_in[7:0];

	// Hold the write target for the data phase
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			dp_write <= 1'b0;
			dp_idx   <= 8'h00;
		end else begin
			dp_write <= take && hwrite_in && (haddr_in[31:10] == 22'h0)
				&& (haddr_in[1:0] == 2'h0);
			dp_idx   <= haddr_in[9:2];
		end
	end

	// Read data registered at the address phase; unmapped reads zero
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			hrdata_out <= 32'h0;
		end else if (take && !hwrite_in) begin
			hrdata_out <= 32'h0;
			if (is_idx(haddr_in, `E1AM_IDX_LIVE))
				hrdata_out[5:0] <= live;
			if (is_idx(haddr_in, `E1AM_IDX_IRQ_EN))
				hrdata_out[5:0] <= irq_en;
			if (is_idx(haddr_in, `E1AM_IDX_CHANGE))
				hrdata_out[5:0] <= change;
			if (is_idx(haddr_in, `E1AM_IDX_CRITERIA)) begin
				hrdata_out[`E1AM_CRIT_AIS_BIT] <= all_ones_criterion_sel;
				hrdata_out[`E1AM_CRIT_RAI_BIT] <= remote_alarm_criterion_sel;
			end
			if (is_idx(haddr_in, `E1AM_IDX_PM_CTRL)) begin
				hrdata_out[`E1AM_PM_MANUAL_BIT] <= perfmon_manual_update;
				hrdata_out[`E1AM_PM_AUTO_BIT]   <= perfmon_auto_update;
			end
			if (is_idx(haddr_in, `E1AM_IDX_OVF_EN_A))
				hrdata_out[7:0] <= ovf_en_a;
			if (is_idx(haddr_in, `E1AM_IDX_OVF_EN_B))
				hrdata_out[`E1AM_LCV_EN_BIT] <= line_code_viol_ovf_irq_en;
			if (is_idx(haddr_in, `E1AM_IDX_OVF_FLG_A))
				hrdata_out[7:0] <= ovf_flag[7:0];
			if (is_idx(haddr_in, `E1AM_IDX_OVF_FLG_B))
				hrdata_out[0] <= ovf_flag[8];
		end
	end

	// Zero wait states, always OKAY
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
		end else begin
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
		end
	end

	// Plain read/write control registers
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			irq_en                     <= 6'h00;
			all_ones_criterion_sel     <= 1'b0;
			remote_alarm_criterion_sel <= 1'b0;
			perfmon_manual_update      <= 1'b0;
			perfmon_auto_update        <= 1'b0;
			ovf_en_a                   <= `E1AM_RESET_BYTE;
			line_code_viol_ovf_irq_en  <= 1'b0;
		end else if (wr) begin
			if (dp_idx == `E1AM_IDX_IRQ_EN)
				irq_en <= wdat[5:0];
			if (dp_idx == `E1AM_IDX_CRITERIA) begin
				all_ones_criterion_sel     <= wdat[`E1AM_CRIT_AIS_BIT];
				remote_alarm_criterion_sel <= wdat[`E1AM_CRIT_RAI_BIT];
			end
			if (dp_idx == `E1AM_IDX_PM_CTRL) begin
				perfmon_manual_update <= wdat[`E1AM_PM_MANUAL_BIT];
				perfmon_auto_update   <= wdat[`E1AM_PM_AUTO_BIT];
			end
			if (dp_idx == `E1AM_IDX_OVF_EN_A)
				ovf_en_a <= wdat;
			if (dp_idx == `E1AM_IDX_OVF_EN_B)
				line_code_viol_ovf_irq_en <= wdat[`E1AM_LCV_EN_BIT];
		end
	end

	// ==========================================================
	// Slot-16 loss: runs of zero and nonzero octets
	logic [4:0] los_zero_run;
	logic [4:0] los_one_run;
	logic       ts16_ok;

	assign ts16_ok = rx_in.ts16_valid && rx_in.frame_aligned;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			los_zero_run <= 5'h0;
			los_one_run  <= 5'h0;
			slot16_loss_status <= 1'b0;
		end else if (ts16_ok) begin
			if (rx_in.ts16_octet == 8'h00) begin
				los_one_run <= 5'h0;
				if (los_zero_run != 5'(`E1AM_LOS_RUN))
					los_zero_run <= los_zero_run + 5'h1;
				if (los_zero_run == 5'(`E1AM_LOS_RUN - 1))
					slot16_loss_status <= 1'b1;
			end else begin
				los_zero_run <= 5'h0;
				if (los_one_run != 5'(`E1AM_LOS_RUN))
					los_one_run <= los_one_run + 5'h1;
				if (los_one_run == 5'(`E1AM_LOS_RUN - 1))
					slot16_loss_status <= 1'b0;
			end
		end
	end

	// Slot-16 AIS: zeros per 16-frame period, saturating at the threshold
	logic [3:0] t16_frame;
	logic [2:0] t16_zeros;
	logic       t16_prev_few;
	logic [4:0] t16_sum;
	logic       t16_few;

	assign t16_sum = {2'h0, t16_zeros} + {1'b0, zeros_in(rx_in.ts16_octet)};
	assign t16_few = t16_sum < 5'(`E1AM_T16_ZERO_MIN);

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			t16_frame    <= 4'h0;
			t16_zeros    <= 3'h0;
			t16_prev_few <= 1'b0;
			slot16_ais_status <= 1'b0;
		end else if (ts16_ok) begin
			t16_frame <= t16_frame + 4'h1;
			if (t16_frame == 4'(`E1AM_T16_PERIOD - 1)) begin
				t16_zeros    <= 3'h0;
				t16_prev_few <= t16_few;
				if (t16_few && t16_prev_few)
					slot16_ais_status <= 1'b1;
				else if (!t16_few)
					slot16_ais_status <= 1'b0;
			end else begin
				t16_zeros <= t16_few ? t16_sum[2:0] : 3'(`E1AM_T16_ZERO_MIN);
			end
		end else if (!rx_in.frame_aligned) begin
			// Period restarts when alignment is regained
			t16_frame <= 4'h0;
			t16_zeros <= 3'h0;
		end
	end

	// Remote multiframe alarm on Y bits
	logic [1:0] y_run;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			y_run   <= 2'h0;
			remote_multiframe_alarm_status <= 1'b0;
		end else if (rx_in.y_valid && rx_in.mf_aligned) begin
			if (rx_in.y_bit) begin
				if (y_run != 2'(`E1AM_Y_RUN))
					y_run <= y_run + 2'h1;
				if (y_run == 2'(`E1AM_Y_RUN - 1))
					remote_multiframe_alarm_status <= 1'b1;
			end else begin
				y_run   <= 2'h0;
				remote_multiframe_alarm_status <= 1'b0;
			end
		end
	end

	// AIS over fixed 512-bit windows of the received stream
	logic [8:0] ais_bit;
	logic [1:0] ais_zeros;
	logic       ais_prev_few;
	logic [1:0] ais_next;
	logic       ais_few;

	assign ais_next = (ais_zeros == 2'(`E1AM_AIS_ZERO_MIN)) ? ais_zeros
		: ais_zeros + {1'b0, ~rx_in.bit_data};
	assign ais_few  = ais_next < 2'(`E1AM_AIS_ZERO_MIN);

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ais_bit      <= 9'h0;
			ais_zeros    <= 2'h0;
			ais_prev_few <= 1'b0;
			all_ones_alarm_status <= 1'b0;
		end else if (rx_in.bit_valid) begin
			ais_bit <= ais_bit + 9'h1;  // Wraps at 512
			if (ais_bit == 9'(`E1AM_AIS_WINDOW - 1)) begin
				ais_zeros    <= 2'h0;
				ais_prev_few <= ais_few;
				if (!all_ones_criterion_sel) begin
					if (ais_few && !rx_in.frame_aligned)
						all_ones_alarm_status <= 1'b1;
					else if (!ais_few)
						all_ones_alarm_status <= 1'b0;
				end else begin
					// Hysteresis: two windows must agree either way
					if (ais_few && ais_prev_few)
						all_ones_alarm_status <= 1'b1;
					else if (!ais_few && !ais_prev_few)
						all_ones_alarm_status <= 1'b0;
				end
			end else begin
				ais_zeros <= ais_next;
			end
		end
	end

	// Remote alarm on A bits
	logic [2:0] a_run;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			a_run   <= 3'h0;
			remote_alarm_status <= 1'b0;
		end else if (rx_in.a_valid && rx_in.frame_aligned) begin
			if (rx_in.a_bit) begin
				if (a_run != 3'(`E1AM_A_RUN))
					a_run <= a_run + 3'h1;
				if (remote_alarm_criterion_sel)
					remote_alarm_status <= 1'b1;
				else if (a_run == 3'(`E1AM_A_RUN - 1))
					remote_alarm_status <= 1'b1;
			end else begin
				a_run   <= 3'h0;
				remote_alarm_status <= 1'b0;
			end
		end
	end

	// Frame-loss alarm: persistence timer restarts on any alignment change
	logic [31:0] red_cnt;
	logic        red_aligned_prev;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			red_cnt          <= 32'h0;
			red_aligned_prev <= 1'b1;
			frame_loss_status <= 1'b0;
		end else begin
			red_aligned_prev <= rx_in.frame_aligned;
			if (rx_in.frame_aligned != red_aligned_prev)
				red_cnt <= 32'h0;
			else if (red_cnt != RED_CYCLES - 1)
				red_cnt <= red_cnt + 32'h1;
			else
				frame_loss_status <= !rx_in.frame_aligned;
		end
	end

	// ==========================================================
	// Change flags: set on toggle wins over a same-cycle clear
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			live_prev <= 6'h00;
			change    <= 6'h00;
		end else begin
			live_prev <= live;
			change    <= (change & ~((wr && dp_idx == `E1AM_IDX_CHANGE)
				? wdat[5:0] : 6'h00))
				| live_toggle;
		end
	end

	// Overflow flags, set wins over clear
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ovf_flag <= 9'h000;
		end else begin
			ovf_flag <= (ovf_flag
				& ~{(wr && dp_idx == `E1AM_IDX_OVF_FLG_B) & wdat[0],
				(wr && dp_idx == `E1AM_IDX_OVF_FLG_A) ? wdat : 8'h00})
				| ovf_pulse_in;
		end
	end

	// Interrupt: OR of set and enabled flags
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(change & irq_en)
				| |(ovf_flag[7:0] & ovf_en_a)
				| (ovf_flag[8] & line_code_viol_ovf_irq_en);
		end
	end

	// ==========================================================
	// Counter update strobe: manual edge or one-second tick
	logic        manual_prev;
	logic [31:0] auto_cnt;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			manual_prev        <= 1'b0;
			auto_cnt           <= 32'h0;
			perfmon_update_out <= 1'b0;
		end else begin
			manual_prev <= perfmon_manual_update;
			if (!perfmon_auto_update || auto_cnt == AUTO_CYCLES - 1)
				auto_cnt <= 32'h0;
			else
				auto_cnt <= auto_cnt + 32'h1;
			perfmon_update_out <= (perfmon_manual_update && !manual_prev)
				|| (perfmon_auto_update && auto_cnt == AUTO_CYCLES - 1);
		end
	end

	// ==========================================================
	// Checks
	los_set_a: assert property (ts16_ok && rx_in.ts16_octet == 8'h00
		&& los_zero_run == 5'(`E1AM_LOS_RUN - 1) |=> live[5])
		else $error("slot16 loss not set after zero run");
	rma_clear_a: assert property (rx_in.y_valid && rx_in.mf_aligned
		&& !rx_in.y_bit |=> !live[3])
		else $error("multiframe alarm not cleared by zero Y");
	rai_run_a: assert property ($rose(live[1]) && !remote_alarm_criterion_sel
		|-> $past(a_run) == 3'(`E1AM_A_RUN - 1))
		else $error("remote alarm rose before four A ones");
	rai_single_a: assert property (remote_alarm_criterion_sel && rx_in.a_valid
		&& rx_in.frame_aligned && rx_in.a_bit |=> live[1])
		else $error("remote alarm not set by single A one");
	red_hold_a: assert property ($rose(live[0]) |-> $past(red_cnt)
		== RED_CYCLES - 1 && !$past(rx_in.frame_aligned, 2))
		else $error("frame loss alarm rose early");
	chg_toggle_a: assert property (live_toggle != 6'h00 |=>
		(change & $past(live_toggle)) == $past(live_toggle))
		else $error("status toggle without change flag");
	chg_hold_a: assert property (change[0] && !(wr && dp_idx ==
		`E1AM_IDX_CHANGE && wdat[0]) |=> change[0])
		else $error("change flag dropped without write one");
	irq_gate_a: assert property ((change & irq_en) != 6'h00 |=> irq_out)
		else $error("enabled change flag did not raise interrupt");
	irq_quiet_a: assert property ((change & irq_en) == 6'h00
		&& (ovf_flag[7:0] & ovf_en_a) == 8'h00
		&& !(ovf_flag[8] && line_code_viol_ovf_irq_en) |=> !irq_out)
		else $error("interrupt without enabled flag");
	upd_edge_a: assert property ($rose(perfmon_manual_update) |=>
		perfmon_update_out)
		else $error("manual update edge gave no strobe");

endmodule : e1am_top

// ### bench/e1am_framer_model.sv
/*
 * Behavioural receive framer: alignment levels, stream strobes and
 * counter overflow pulses for the alarm supervisor.
 * Assumes the bench calls its tasks just after a rising clock edge.
 */
module e1am_framer_model (
	// Clock
	input  wire logic           clk_in,
	// Stream towards the supervisor
	output e1am_pkg::e1am_rx_s  rx_out,
	output e1am_pkg::e1am_ovf_t ovf_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Idle state: aligned, no strobes
	initial begin
		rx_out = '0;
		rx_out.frame_aligned = 1'b1;
		rx_out.mf_aligned = 1'b1;
		ovf_out = '0;
	end

	// Basic frame alignment level
	task automatic set_align(input logic fa);
		@(posedge clk_in);
		rx_out.frame_aligned <= fa;
	endtask : set_align

	// Multiframe alignment level
	task automatic set_mf_align(input logic ma);
		@(posedge clk_in);
		rx_out.mf_aligned <= ma;
	endtask : set_mf_align

	// One strobe of kind 0 slot 16, 1 A bit, 2 Y bit, 3 line bit; data
	// turns to its inverse afterwards so a stale value never passes
	task automatic strobe(input logic [1:0] kind, input logic [7:0] v);
		@(posedge clk_in);
		rx_out.ts16_octet <= v;
		rx_out.a_bit      <= v[0];
		rx_out.y_bit      <= v[0];
		rx_out.bit_data   <= v[0];
		rx_out.ts16_valid <= (kind == 2'h0);
		rx_out.a_valid    <= (kind == 2'h1);
		rx_out.y_valid    <= (kind == 2'h2);
		rx_out.bit_valid  <= (kind == 2'h3);
		@(posedge clk_in);
		rx_out.ts16_valid <= 1'b0;
		rx_out.a_valid    <= 1'b0;
		rx_out.y_valid    <= 1'b0;
		rx_out.bit_valid  <= 1'b0;
		rx_out.ts16_octet <= ~v;
		rx_out.a_bit      <= ~v[0];
		rx_out.y_bit      <= ~v[0];
		rx_out.bit_data   <= ~v[0];
	endtask : strobe

	// One-cycle overflow pulse
	task automatic pulse_ovf(input e1am_pkg::e1am_ovf_t v);
		@(posedge clk_in);
		ovf_out <= v;
		@(posedge clk_in);
		ovf_out <= '0;
	endtask : pulse_ovf
endmodule : e1am_framer_model

// ### bench/tb_e1_alarm_monitor_irq.sv
/*
 * Self-checking bench for the alarm supervisor: AHB-Lite master tasks
 * and one task per scenario.
 * Assumes shortened RED and auto-update counts set at the instance.
 */
`include "e1am_consts.svh"

module tb_e1_alarm_monitor_irq;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Signals and register indices
	localparam logic [7:0] LIVE = `E1AM_IDX_LIVE;
	localparam logic [7:0] IEN  = `E1AM_IDX_IRQ_EN;
	localparam logic [7:0] CHG  = `E1AM_IDX_CHANGE;
	localparam logic [7:0] CRIT = `E1AM_IDX_CRITERIA;
	localparam logic [7:0] PMC  = `E1AM_IDX_PM_CTRL;
	localparam logic [7:0] OEA  = `E1AM_IDX_OVF_EN_A;
	localparam logic [7:0] OEB  = `E1AM_IDX_OVF_EN_B;
	localparam logic [7:0] OFA  = `E1AM_IDX_OVF_FLG_A;
	localparam logic [7:0] OFB  = `E1AM_IDX_OVF_FLG_B;
	logic                clk_in = 1'b0;
	logic                rst_in = 1'b1;
	logic                hsel_in = 1'b0;
	logic [31:0]         haddr_in = '0;
	logic [1:0]          htrans_in = 2'h0;
	logic                hwrite_in = 1'b0;
	logic [31:0]         hwdata_in = '0;
	logic [2:0]          hsize_in = 3'h0;
	logic [31:0]         hrdata_out;
	logic                hreadyout_out;
	logic                hresp_out;
	logic                irq_out;
	logic                perfmon_update_out;
	e1am_pkg::e1am_rx_s  rx;
	e1am_pkg::e1am_ovf_t ovf;
	int                  n_errors = 0;
	int                  n_tests = 0;
	int                  n_upd = 0;

	// 10 MHz clock
	always #50 clk_in = ~clk_in;

	// Update pulse counter
	always @(posedge clk_in) begin
		if (perfmon_update_out === 1'b1) begin
			n_upd++;
		end
	end

	e1am_top #(.RED_CYCLES(20), .AUTO_CYCLES(30)) i_e1am_top (
		.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel_in),
		.haddr_in(haddr_in), .htrans_in(htrans_in),
		.hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
		.hready_in(hreadyout_out), .hrdata_out(hrdata_out),
		.hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
		.rx_in(rx), .ovf_pulse_in(ovf), .irq_out(irq_out),
		.perfmon_update_out(perfmon_update_out));

	e1am_framer_model i_e1am_framer_model (
		.clk_in(clk_in), .rx_out(rx), .ovf_out(ovf));

	// ==========================================================
	// Comparison, verdict and bus tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
			n_errors++;
		end
	endtask : chk

	task automatic summarize;
		$display("errors %0d comparisons %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : summarize

	// Bounded wait for hready at a rising edge
	task automatic wait_rdy;
		int n;
		n = 0;
		@(posedge clk_in);
		while (hreadyout_out !== 1'b1 && n < 50) begin
			n++;
			@(posedge clk_in);
		end
		if (n >= 50) begin
			chk(32'h0, 32'h1);
			summarize();
		end
	endtask : wait_rdy

	// Single word transfer; read data taken at the data phase edge
	task automatic bus(input logic w, input logic [7:0] idx,
		input logic [7:0] wd, output logic [31:0] rd);
		hsel_in   <= 1'b1;
		haddr_in  <= {22'h000000, idx, 2'h0};
		htrans_in <= 2'h2;
		hwrite_in <= w;
		hsize_in  <= 3'h2;
		wait_rdy();
		hsel_in   <= 1'b0;
		htrans_in <= 2'h0;
		hwdata_in <= {24'h000000, wd};
		wait_rdy();
		rd = hrdata_out;
		chk({31'h0, hresp_out}, 32'h0);
	endtask : bus

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] x;
		bus(1'b1, idx, d, x);
	endtask : wr

	// Read and compare under a mask
	task automatic rchk(input logic [7:0] idx, input logic [7:0] e,
		input logic [7:0] m);
		logic [31:0] r;
		bus(1'b0, idx, 8'h00, r);
		chk(r & {24'h000000, m}, {24'h000000, e});
	endtask : rchk

	task automatic irq(input logic e);
		chk({31'h0, irq_out}, {31'h0, e});
	endtask : irq

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		logic [7:0] ids [10];
		ids = '{LIVE, IEN, CHG, CRIT, PMC, OEA, OEB, OFA, OFB, 8'hbd};
		foreach (ids[i]) rchk(ids[i], 8'h00, 8'hff);
		irq(1'b0);
	endtask : t_reset

	// Read-write places keep data; status and unmapped places do not
	task automatic t_rw;
		wr(IEN, 8'h3f);
		wr(CRIT, 8'h30);
		wr(OEA, 8'hff);
		wr(OEB, 8'h01);
		wr(LIVE, 8'h3f);
		wr(8'hbd, 8'hff);
		rchk(IEN, 8'h3f, 8'h3f);
		rchk(CRIT, 8'h30, 8'h30);
		rchk(OEA, 8'hff, 8'hff);
		rchk(OEB, 8'h01, 8'h01);
		rchk(LIVE, 8'h00, 8'hff);
		rchk(8'hbd, 8'h00, 8'hff);
		wr(IEN, 8'h00);
		wr(CRIT, 8'h00);
		wr(OEA, 8'h00);
		wr(OEB, 8'h00);
	endtask : t_rw

	// Four A ones raise the remote alarm, one zero drops it
	task automatic t_remote;
		wr(IEN, 8'h02);
		repeat (3) i_e1am_framer_model.strobe(2'h1, 8'h01);
		rchk(LIVE, 8'h00, 8'h02);
		i_e1am_framer_model.strobe(2'h1, 8'h01);
		repeat (3) @(posedge clk_in);
		rchk(LIVE, 8'h02, 8'h02);
		rchk(CHG, 8'h02, 8'hff);
		irq(1'b1);
		wr(CHG, 8'h00);
		rchk(CHG, 8'h02, 8'hff);
		wr(CHG, 8'h02);
		rchk(CHG, 8'h00, 8'hff);
		irq(1'b0);
		i_e1am_framer_model.strobe(2'h1, 8'h00);
		repeat (3) @(posedge clk_in);
		rchk(LIVE, 8'h00, 8'h02);
		rchk(CHG, 8'h02, 8'hff);
		wr(IEN, 8'h00);
		wr(CHG, 8'h3f);
	endtask : t_remote

	// Criterion one: a single A bit decides
	task automatic t_remote_single;
		wr(CRIT, 8'h10);
		i_e1am_framer_model.strobe(2'h1, 8'h01);
		repeat (3) @(posedge clk_in);
		rchk(LIVE, 8'h02, 8'h02);
		i_e1am_framer_model.strobe(2'h1, 8'h00);
		repeat (3) @(posedge clk_in);
		rchk(LIVE, 8'h00, 8'h02);
		wr(CRIT, 8'h00);
		wr(CHG, 8'h3f);
	endtask : t_remote_single

	task automatic t_multiframe;
		// Y ones are ignored while the multiframe is unaligned
		i_e1am_framer_model.set_mf_align(1'b0);
		repeat (3) i_e1am_framer_model.strobe(2'h2, 8'h01);
		rchk(LIVE, 8'h00, 8'h08);
		i_e1am_framer_model.set_mf_align(1'b1);
		repeat (2) i_e1am_framer_model.strobe(2'h2, 8'h01);
		rchk(LIVE, 8'h00, 8'h08);
		i_e1am_framer_model.strobe(2'h2, 8'h01);
		repeat (3) @(posedge clk_in);
		rchk(LIVE, 8'h08, 8'h08);
		i_e1am_framer_model.strobe(2'h2, 8'h00);
		repeat (3) @(posedge clk_in);
		rchk(LIVE, 8'h00, 8'h08);
	endtask : t_multiframe

	// Fifteen octets are one short of the run in both directions
	task automatic t_slot16;
		repeat (15) i_e1am_framer_model.strobe(2'h0, 8'h00);
		rchk(LIVE, 8'h00, 8'h20);
		i_e1am_framer_model.strobe(2'h0, 8'h00);
		repeat (3) @(posedge clk_in);
		rchk(LIVE, 8'h20, 8'h20);
		repeat (15) i_e1am_framer_model.strobe(2'h0, 8'h55);
		rchk(LIVE, 8'h20, 8'h20);
		i_e1am_framer_model.strobe(2'h0, 8'h55);
		repeat (3) @(posedge clk_in);
		rchk(LIVE, 8'h00, 8'h30);
		// One quiet period is not enough, the second declares slot-16 AIS
		repeat (16) i_e1am_framer_model.strobe(2'h0, 8'hff);
		rchk(LIVE, 8'h00, 8'h10);
		repeat (16) i_e1am_framer_model.strobe(2'h0, 8'hff);
		rchk(LIVE, 8'h10, 8'h30);
		repeat (16) i_e1am_framer_model.strobe(2'h0, 8'h0f);
		rchk(LIVE, 8'h00, 8'h30);
	endtask : t_slot16

	// All-ones window while unaligned, then a window of zeros
	task automatic t_ais_red;
		i_e1am_framer_model.set_align(1'b0);
		repeat (5) @(posedge clk_in);
		rchk(LIVE, 8'h00, 8'h01);
		repeat (512) i_e1am_framer_model.strobe(2'h3, 8'h01);
		repeat (3) @(posedge clk_in);
		rchk(LIVE, 8'h05, 8'h05);
		i_e1am_framer_model.set_align(1'b1);
		repeat (30) @(posedge clk_in);
		rchk(LIVE, 8'h00, 8'h01);
		repeat (512) i_e1am_framer_model.strobe(2'h3, 8'h00);
		repeat (3) @(posedge clk_in);
		rchk(LIVE, 8'h00, 8'h04);
		wr(CHG, 8'h3f);
	endtask : t_ais_red

	// Criterion one: two agreeing windows either way, even when aligned
	task automatic t_ais_two;
		logic [7:0] e;
		wr(CRIT, 8'h20);
		for (int w = 0; w < 4; w++) begin
			repeat (512) i_e1am_framer_model.strobe(2'h3, {7'h00, w < 2});
			e = (w == 1 || w == 2) ? 8'h04 : 8'h00;
			rchk(LIVE, e, 8'h04);
		end
		wr(CRIT, 8'h00);
		wr(CHG, 8'h3f);
	endtask : t_ais_two

	task automatic t_update;
		int k;
		k = n_upd;
		wr(PMC, 8'h20);
		repeat (4) @(posedge clk_in);
		chk(32'(n_upd - k), 32'h1);
		wr(PMC, 8'h20);
		repeat (4) @(posedge clk_in);
		chk(32'(n_upd - k), 32'h1);
		wr(PMC, 8'h00);
		k = n_upd;
		wr(PMC, 8'h10);
		repeat (75) @(posedge clk_in);
		chk(32'(n_upd - k), 32'h2);
		wr(PMC, 8'h00);
		repeat (3) @(posedge clk_in);
		k = n_upd;
		repeat (75) @(posedge clk_in);
		chk(32'(n_upd - k), 32'h0);
	endtask : t_update

	task automatic t_overflow;
		wr(OEA, 8'h80);
		i_e1am_framer_model.pulse_ovf(9'h081);
		repeat (3) @(posedge clk_in);
		rchk(OFA, 8'h81, 8'hff);
		irq(1'b1);
		wr(OFA, 8'h80);
		rchk(OFA, 8'h01, 8'hff);
		irq(1'b0);
		wr(OEB, 8'h01);
		i_e1am_framer_model.pulse_ovf(9'h100);
		repeat (3) @(posedge clk_in);
		rchk(OFB, 8'h01, 8'h01);
		irq(1'b1);
		wr(OFB, 8'h01);
		wr(OFA, 8'hff);
		repeat (2) @(posedge clk_in);
		irq(1'b0);
	endtask : t_overflow

	// ==========================================================
	// Main sequence
	initial begin
		repeat (20) @(posedge clk_in);
		rst_in <= 1'b0;
		t_reset();
		t_rw();
		t_remote();
		t_remote_single();
		t_multiframe();
		t_slot16();
		t_ais_red();
		t_ais_two();
		t_update();
		t_overflow();
		summarize();
	end
endmodule : tb_e1_alarm_monitor_irq
